// *** verilog/ubi_pkg.sv ***
`default_nettype none
package ubi_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] UBI_OFF_BAUD = 8'h24;
	localparam logic [7:0] UBI_OFF_IRCTL = 8'h28;
	localparam logic [7:0] UBI_OFF_FUNC = 8'h30;
	localparam logic [31:0] UBI_BAUD_RST = 32'h0f000000;
	localparam logic [31:0] UBI_IRCTL_RST = 32'h00000040;
	localparam logic [31:0] UBI_FUNC_RST = 32'h00000000;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int UBI_DIVISOR_LSB = 0;
	localparam int UBI_DIVISOR_W = 16;
	localparam int UBI_DIVX_LSB = 24;
	localparam int UBI_DIVX_W = 4;
	localparam int UBI_DIVX_ONE_BIT = 28;
	localparam int UBI_DIVX_EN_BIT = 29;
	localparam logic [31:0] UBI_BAUD_MASK = 32'h3f00ffff;
	localparam int UBI_RX_INVERT_BIT = 6;
	localparam int UBI_TX_INVERT_BIT = 5;
	localparam int UBI_TX_SEL_BIT = 1;
	localparam logic [31:0] UBI_IRCTL_MASK = 32'h00000062;
	localparam logic [31:0] UBI_FUNC_MASK = 32'h00000003;
	localparam logic [1:0] UBI_FUNC_IRDA = 2'h2;
	localparam logic [4:0] UBI_M_FIXED = 5'h10;
	localparam logic [31:0] UBI_UNMAPPED = 32'h00000000;
endpackage
`default_nettype wire

// *** verilog/ubi_sync.sv ***
`default_nettype none
module ubi_sync
	import ubi_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// level
	input wire logic d_in,
	output logic q_out
);
	typedef struct packed {
		logic s1;
		logic s2;
	} ubi_sync_t;
	ubi_sync_t st_q, st_d;
	always_comb begin
		st_d.s1 = d_in;
		st_d.s2 = st_q.s1;
	end
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign q_out = st_q.s2;
endmodule
`default_nettype wire

// *** verilog/ubi_divider.sv ***
`default_nettype none
module ubi_divider
	import ubi_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// settings
	input wire logic [15:0] divisor_in,
	input wire logic [4:0] m_in,
	// ticks
	output logic tick_out,
	output logic bit_out
);
	typedef struct packed {
		logic [4:0] pre;
		logic [16:0] div;
		logic [16:0] div_lim;
		logic [4:0] m_lim;
		logic tick;
		logic bitp;
	} ubi_div_t;
	ubi_div_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		st_d.bitp = 1'b0;
		// oversample ticks: one per (divisor+2) clocks; m ticks per bit
		if (st_q.div >= st_q.div_lim) begin
			st_d.div = '0;
			st_d.tick = 1'b1;
			if (st_q.pre >= st_q.m_lim) begin
				st_d.pre = '0;
				st_d.bitp = 1'b1;
				// new settings land only at a bit boundary
				st_d.div_lim = 17'(divisor_in) + 17'h00001;
				st_d.m_lim = m_in - 5'h01;
			end else begin
				st_d.pre = st_q.pre + 5'h01;
			end
		end else begin
			st_d.div = st_q.div + 17'h00001;
		end
	end
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= '{pre: 5'h00, div: 17'h00000,
				div_lim: 17'(UBI_BAUD_RST[UBI_DIVISOR_LSB +: UBI_DIVISOR_W]) + 17'h00001,
				m_lim: UBI_M_FIXED - 5'h01,
				tick: 1'b0, bitp: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end
	assign tick_out = st_q.tick;
	assign bit_out = st_q.bitp;
endmodule
`default_nettype wire

// *** verilog/ubi_top.sv ***
// The implementer's own choice: the Avalon-MM interface to the registers.
`default_nettype none
// Notes on behaviour
// - bit rate is clock divided by m times (divisor plus two).
// - with scale enable clear, m is sixteen.
// - with scale enable set, m is one if unity select set, else factor field plus one.
// - the factor field matters only in mode 1.
// - the sixteen-bit divisor sits in the low half of the divisor register.
// - receive invert bit inverts the infrared input; resets to one.
// - transmit invert bit inverts the infrared output; resets to zero.
// - direction bit zero enables receive only, one enables transmit only.
// - infrared settings act only when function select holds binary ten.
module ubi_top
	import ubi_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// avalon-mm slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// uart core side
	input wire logic core_txd_in,
	output logic core_rxd_out,
	output logic baud_tick_out,
	output logic bit_tick_out,
	output logic [1:0] baud_mode_out,
	output logic [1:0] function_select_out,
	// infrared transceiver
	input wire logic ir_rxd_in,
	output logic ir_txd_out
);
	typedef enum logic [1:0] {
		UBI_IDLE = 2'b00,
		UBI_ACK = 2'b01
	} ubi_bus_t;

	typedef enum logic [1:0] {
		UBI_MODE0 = 2'b00,
		UBI_MODE1 = 2'b01,
		UBI_MODE2 = 2'b11
	} ubi_mode_t;

	typedef struct packed {
		ubi_bus_t bus;
		logic [31:0] baud_divisor;
		logic [31:0] infrared_control;
		logic [31:0] function_select;
		logic [31:0] rdata;
		logic rxd;
		logic txd;
	} ubi_state_t;

	ubi_state_t st_q, st_d;
	logic ir_rxd_sync;
	logic [4:0] m_sel;
	ubi_mode_t mode;
	logic ir_active;

	function automatic logic [31:0] ubi_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r & mask;
	endfunction

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	ubi_sync u_sync (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.d_in(ir_rxd_in),
		.q_out(ir_rxd_sync)
	);

	// ----------------------------------------
	// mode and factor decode
	// ----------------------------------------
	always_comb begin
		if (!st_q.baud_divisor[UBI_DIVX_EN_BIT]) begin
			mode = UBI_MODE0;
		end else if (!st_q.baud_divisor[UBI_DIVX_ONE_BIT]) begin
			mode = UBI_MODE1;
		end else begin
			mode = UBI_MODE2;
		end
		unique case (mode)
			UBI_MODE0: m_sel = UBI_M_FIXED;
			UBI_MODE1: m_sel = 5'(st_q.baud_divisor[UBI_DIVX_LSB +: UBI_DIVX_W]) + 5'h01;
			UBI_MODE2: m_sel = 5'h01;
			default: m_sel = UBI_M_FIXED;
		endcase
	end

	// ----------------------------------------
	// baud generator
	// ----------------------------------------
	ubi_divider u_div (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.divisor_in(st_q.baud_divisor[UBI_DIVISOR_LSB +: UBI_DIVISOR_W]),
		.m_in(m_sel),
		.tick_out(baud_tick_out),
		.bit_out(bit_tick_out)
	);

	// ----------------------------------------
	// registers and line path
	// ----------------------------------------
	assign ir_active = (st_q.function_select[1:0] == UBI_FUNC_IRDA);

	always_comb begin
		st_d = st_q;
		unique case (st_q.bus)
			UBI_IDLE: begin
				if (avs_write_in) begin
					st_d.bus = UBI_ACK;
					unique case (avs_address_in)
						UBI_OFF_BAUD: st_d.baud_divisor = ubi_merge(st_q.baud_divisor,
							avs_writedata_in, avs_byteenable_in, UBI_BAUD_MASK);
						UBI_OFF_IRCTL: st_d.infrared_control = ubi_merge(st_q.infrared_control,
							avs_writedata_in, avs_byteenable_in, UBI_IRCTL_MASK);
						UBI_OFF_FUNC: st_d.function_select = ubi_merge(st_q.function_select,
							avs_writedata_in, avs_byteenable_in, UBI_FUNC_MASK);
						default: st_d.bus = UBI_ACK;
					endcase
				end else if (avs_read_in) begin
					st_d.bus = UBI_ACK;
					unique case (avs_address_in)
						UBI_OFF_BAUD: st_d.rdata = st_q.baud_divisor;
						UBI_OFF_IRCTL: st_d.rdata = st_q.infrared_control;
						UBI_OFF_FUNC: st_d.rdata = st_q.function_select;
						default: st_d.rdata = UBI_UNMAPPED;
					endcase
				end
			end
			UBI_ACK: st_d.bus = UBI_IDLE;
			default: st_d.bus = UBI_IDLE;
		endcase
		// half duplex: idle line level while the unused direction is off
		if (ir_active) begin
			st_d.rxd = st_q.infrared_control[UBI_TX_SEL_BIT] ? 1'b1 :
				(ir_rxd_sync ^ st_q.infrared_control[UBI_RX_INVERT_BIT]);
			st_d.txd = st_q.infrared_control[UBI_TX_SEL_BIT] ?
				(core_txd_in ^ st_q.infrared_control[UBI_TX_INVERT_BIT]) :
				st_q.infrared_control[UBI_TX_INVERT_BIT];
		end else begin
			st_d.rxd = ir_rxd_sync;
			st_d.txd = core_txd_in;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q <= '{bus: UBI_IDLE, baud_divisor: UBI_BAUD_RST, infrared_control: UBI_IRCTL_RST,
				function_select: UBI_FUNC_RST, rdata: 32'h00000000, rxd: 1'b1, txd: 1'b1};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// waitrequest drops in the ack cycle, so each access takes two edges
	assign avs_waitrequest_out = (st_q.bus != UBI_ACK);
	assign avs_readdata_out = st_q.rdata;
	assign core_rxd_out = st_q.rxd;
	assign ir_txd_out = st_q.txd;
	assign baud_mode_out = mode;
	assign function_select_out = st_q.function_select[1:0];
endmodule
`default_nettype wire

// *** tb/ubi_assertions.sv ***
`default_nettype none
module ubi_assertions
	import ubi_pkg::*;
(
	// watched ports
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	input wire logic core_txd_in,
	input wire logic ir_rxd_in,
	input wire logic core_rxd_out,
	input wire logic baud_tick_out,
	input wire logic bit_tick_out,
	input wire logic [1:0] baud_mode_out,
	input wire logic [1:0] function_select_out,
	input wire logic ir_txd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	property p_ack_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack too long");
	property p_take; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	a_take: assert property (p_take) else $error("no ack");
	property p_ack_req; !avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in);
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("stray ack");
	property p_tick_gap; baud_tick_out |=> !baud_tick_out; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("baud tick");
	property p_bit_gap; $rose(bit_tick_out) |=> $fell(bit_tick_out); endproperty
	a_bit_gap: assert property (p_bit_gap) else $error("bit tick");
	property p_bit_on_tick; bit_tick_out |-> baud_tick_out; endproperty
	a_bit_on_tick: assert property (p_bit_on_tick) else $error("bit off tick");
	property p_mode; baud_mode_out != 2'h2; endproperty
	a_mode: assert property (p_mode) else $error("mode code");
	property p_tx_pass; function_select_out != UBI_FUNC_IRDA ##1 function_select_out !=
		UBI_FUNC_IRDA |-> ir_txd_out == $past(core_txd_in); endproperty
	a_tx_pass: assert property (p_tx_pass) else $error("tx path");
	property p_rx_pass; (function_select_out != UBI_FUNC_IRDA)[*4] |->
		core_rxd_out == $past(ir_rxd_in, 3); endproperty
	a_rx_pass: assert property (p_rx_pass) else $error("rx path");
endmodule
`default_nettype wire

// *** tb/ubi_ir_xcvr.sv ***
`default_nettype none
// optical front end: light seen becomes the receive pin one clock later
module ubi_ir_xcvr (
	input wire logic mclk_in,
	input wire logic light_in,
	output logic rxd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk_in) rxd_out <= light_in;
endmodule
`default_nettype wire

// *** tb/ubi_top_test.sv ***
`default_nettype none
module ubi_top_test
	import ubi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 0, reset_n_in = 0, avs_read_in = 0, avs_write_in = 0, core_txd_in = 1;
	logic light = 1, avs_waitrequest_out, core_rxd_out, baud_tick_out, bit_tick_out;
	logic ir_rxd_in, ir_txd_out;
	logic [7:0] avs_address_in = 8'h00;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
	logic [3:0] avs_byteenable_in = 4'hf;
	logic [1:0] baud_mode_out, function_select_out;
	int miscompares = 0, n_checks = 0;
	always #2 mclk_in = ~mclk_in;
	ubi_top dut_u(.*);
	ubi_ir_xcvr xcvr_u(.mclk_in(mclk_in), .light_in(light), .rxd_out(ir_rxd_in));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task bus(input logic r, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_byteenable_in <= b;
		avs_read_in <= r;
		avs_write_in <= !r;
		do begin
			@(posedge mclk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 0;
		avs_write_in <= 0;
		@(posedge mclk_in);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1, a, 32'h0, 4'hf);
		chk(q, e);
	endtask
	task rt(input logic [31:0] v, input logic [31:0] per, input logic [31:0] m,
		input logic [1:0] md);
		int c;
		int nb;
		bus(0, UBI_OFF_BAUD, v, 4'hf);
		// new setting only lands on a bit boundary
		repeat (3) begin
			c = 0;
			nb = 0;
			do begin
				@(posedge mclk_in);
				c++;
				if (baud_tick_out === 1'b1) begin
					nb++;
				end
			end while (bit_tick_out !== 1'b1 && c < 5000);
		end
		chk(c, per);
		chk(nb, m);
		chk({30'h0, baud_mode_out}, {30'h0, md});
	endtask
	task irc(input logic [1:0] f, input logic [31:0] c, input logic t, l, et, er);
		bus(0, UBI_OFF_FUNC, {30'h0, f}, 4'hf);
		bus(0, UBI_OFF_IRCTL, c, 4'hf);
		core_txd_in <= t;
		light <= l;
		repeat (6) @(posedge mclk_in);
		chk({30'h0, function_select_out}, {30'h0, f});
		chk({31'h0, ir_txd_out}, {31'h0, et});
		chk({31'h0, core_rxd_out}, {31'h0, er});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rd(UBI_OFF_BAUD, 32'h0f000000);
		rd(UBI_OFF_IRCTL, 32'h00000040);
		rd(UBI_OFF_FUNC, 32'h0);
		bus(0, UBI_OFF_IRCTL, 32'hffffffff, 4'hf);
		rd(UBI_OFF_IRCTL, 32'h00000062);
		bus(0, UBI_OFF_BAUD, 32'hffffffff, 4'h1);
		rd(UBI_OFF_BAUD, 32'h0f0000ff);
		bus(0, 8'h3c, 32'hffffffff, 4'hf);
		rd(8'h3c, 32'h0);
		$display("register test done");
	endtask
	task t_rate;
		rt(32'h00000003, 32'd80, 32'd16, 2'h0);
		rt(32'h28000001, 32'd27, 32'd9, 2'h1);
		rt(32'h2a000000, 32'd22, 32'd11, 2'h1);
		rt(32'h3f000004, 32'd6, 32'd1, 2'h3);
		rt(32'h0f000002, 32'd64, 32'd16, 2'h0);
		$display("rate test done");
	endtask
	task t_ir;
		irc(2'h0, 32'h62, 1, 0, 1, 0);
		irc(2'h2, 32'h40, 1, 0, 0, 1);
		irc(2'h2, 32'h00, 1, 1, 0, 1);
		irc(2'h2, 32'h22, 1, 0, 0, 1);
		irc(2'h2, 32'h02, 1, 1, 1, 1);
		irc(2'h2, 32'h20, 0, 0, 1, 0);
		irc(2'h3, 32'h62, 0, 1, 0, 1);
		irc(2'h1, 32'h40, 0, 0, 0, 0);
		$display("infrared test done");
	endtask
	task give_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk_in);
		reset_n_in <= 1;
		@(posedge mclk_in);
		t_regs;
		t_rate;
		t_ir;
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		miscompares++;
		give_verdict;
	end
endmodule
bind ubi_top ubi_assertions chk_u(.*);
`default_nettype wire
